// ===== gport_ctrl.sv
// How it works
// - Status 111 lets master start framed transactions.
// - Strobe 0 times low data and enables.
// - Strobe 1 times high data and enables.
// - Data source drives strobes in fast writes only; receiver leaves undriven.
// - Each strobe has a complementary partner.
// - As initiator, drive frame over whole access.
// - As target, capture address/command on first frame.
// - Fast writes are framed by driven frame.
// - Frame ignored while queued request modes selected.
// - Ready lines unused for enqueueing, used for data.
// - Initiator ready driven as initiator, sampled as target.
// - Target ready sampled as initiator, driven as target.
// - Fast write: ready with first word, no waits inside a block.
// - Fast write waits only at 32-byte block boundaries.
// - Grant and status driven together.
`include "gport_regs.svh"

module gport_ctrl
  import gport_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Port clock, sampled
  input wire logic port_clk,
  // Arbiter side
  input wire logic grant_req,
  input wire logic [`ST_WIDTH-1:0] grant_code,
  input wire logic queue_mode,
  // Initiator user side
  input wire logic init_start,
  input wire logic init_fast,
  input wire logic [`CBE_WIDTH-1:0] init_cmd,
  input wire logic [`AD_WIDTH-1:0] init_addr,
  input wire logic [`WORDS_WIDTH-1:0] init_words,
  input wire logic init_data_ready,
  input wire logic [`AD_WIDTH-1:0] init_data,
  output logic init_pop,
  output logic init_busy,
  output logic init_done,
  // Target user side
  output logic tgt_hit,
  output logic [`CBE_WIDTH-1:0] tgt_cmd,
  output logic [`AD_WIDTH-1:0] tgt_addr,
  output logic tgt_valid,
  output logic [`AD_WIDTH-1:0] tgt_data,
  output logic [`CBE_WIDTH-1:0] tgt_be_n,
  // Arbiter pins
  output logic grant_n,
  output logic [`ST_WIDTH-1:0] st,
  // Frame and ready pins
  input wire logic frame_n_in,
  output logic frame_n_out,
  output logic frame_oe,
  input wire logic port_initiator_ready_n_in,
  output logic port_initiator_ready_n_out,
  output logic port_initiator_ready_n_oe,
  input wire logic port_target_ready_n_in,
  output logic port_target_ready_n_out,
  output logic port_target_ready_n_oe,
  // Address/data pins
  input wire logic [`AD_WIDTH-1:0] ad_in,
  output logic [`AD_WIDTH-1:0] ad_out,
  output logic ad_oe,
  input wire logic [`CBE_WIDTH-1:0] cbe_n_in,
  output logic [`CBE_WIDTH-1:0] cbe_n_out,
  output logic cbe_oe,
  // Data strobe pins
  output logic ad_stb0,
  output logic ad_stb0_n,
  output logic ad_stb0_oe,
  output logic ad_stb1,
  output logic ad_stb1_n,
  output logic ad_stb1_oe
);

  function automatic logic is_init(input port_state_type s);
    is_init = (s == S_INIT_ADDR) || (s == S_INIT_DATA) || (s == S_INIT_END);
  endfunction

  function automatic logic is_tgt(input port_state_type s);
    is_tgt = (s == S_TGT_DATA) || (s == S_TGT_END);
  endfunction

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  // Every pin input passes two flops; the port clock edge is found on the
  // second stage, so all pins are seen at the same instant as the edge.
  logic [`SYNC_WIDTH-1:0] sync1_q, sync2_q;
  logic pclk_prev_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      pclk_prev_q <= 1'b0;
    end else begin
      sync1_q <= {port_clk, frame_n_in, port_initiator_ready_n_in, port_target_ready_n_in, cbe_n_in, ad_in};
      sync2_q <= sync1_q;
      pclk_prev_q <= sync2_q[39];
    end
  end

  logic edge_s, frame_n_s, irdy_n_s, trdy_n_s;
  logic [`CBE_WIDTH-1:0] cbe_n_s;
  logic [`AD_WIDTH-1:0] ad_s;
  assign edge_s = sync2_q[39] & ~pclk_prev_q;
  assign frame_n_s = sync2_q[38];
  assign irdy_n_s = sync2_q[37];
  assign trdy_n_s = sync2_q[36];
  assign cbe_n_s = sync2_q[35:32];
  assign ad_s = sync2_q[31:0];

  // --------------------------------------------------------------------------
  // Transaction state
  // --------------------------------------------------------------------------
  port_state_type state_q, state_d;
  logic gnt_n_q, gnt_n_d, fast_q, fast_d;
  logic [`ST_WIDTH-1:0] st_q, st_d;
  logic frame_n_q, frame_n_d, frame_oe_q, frame_oe_d;
  logic irdy_n_q, irdy_n_d, trdy_n_q, trdy_n_d;
  logic [`AD_WIDTH-1:0] ad_q, ad_d, taddr_q, taddr_d, tdata_q, tdata_d;
  logic ad_oe_q, ad_oe_d;
  logic [`CBE_WIDTH-1:0] cbe_q, cbe_d, tcmd_q, tcmd_d, tbe_q, tbe_d;
  logic [`WORDS_WIDTH-1:0] left_q, left_d;
  logic [`BLK_WIDTH-1:0] blk_q, blk_d;
  logic pop_q, pop_d, done_q, done_d, hit_q, hit_d, tvalid_q, tvalid_d;
  logic phase_done;

  // A data phase completes when both ready lines are low at a port edge.
  // Ready lines are looked at here and in the target data state, never to enqueue requests.
  assign phase_done = edge_s && !irdy_n_q && !trdy_n_s;

  always_comb begin
    state_d = state_q;
    gnt_n_d = gnt_n_q;
    st_d = st_q;
    fast_d = fast_q;
    frame_n_d = frame_n_q;
    frame_oe_d = frame_oe_q;
    irdy_n_d = irdy_n_q;
    trdy_n_d = trdy_n_q;
    ad_d = ad_q;
    ad_oe_d = ad_oe_q;
    cbe_d = cbe_q;
    taddr_d = taddr_q;
    tcmd_d = tcmd_q;
    tdata_d = tdata_q;
    tbe_d = tbe_q;
    left_d = left_q;
    blk_d = blk_q;
    pop_d = 1'b0;
    done_d = 1'b0;
    hit_d = 1'b0;
    tvalid_d = 1'b0;
    if (edge_s) begin
      gnt_n_d = ~grant_req;
      st_d = grant_code;
      case (state_q)
        S_IDLE: begin
          if (init_start) begin
            state_d = S_INIT_ADDR;
            fast_d = init_fast;
            frame_n_d = 1'b0;
            frame_oe_d = 1'b1;
            irdy_n_d = 1'b1;
            ad_d = init_addr;
            ad_oe_d = 1'b1;
            cbe_d = init_cmd;
            left_d = init_words;
            blk_d = '0;
          end else if (!queue_mode && !frame_n_s) begin
            state_d = S_TGT_DATA;
            taddr_d = ad_s;
            tcmd_d = cbe_n_s;
            hit_d = 1'b1;
            trdy_n_d = 1'b0;
          end
        end
        S_INIT_ADDR: begin
          state_d = S_INIT_DATA;
          cbe_d = `CBE_ALL_BYTES;
          frame_n_d = (left_q == 6'h1);
          if (init_data_ready) begin
            irdy_n_d = 1'b0;
            ad_d = init_data;
            pop_d = 1'b1;
          end
        end
        S_INIT_DATA: begin
          if (phase_done) begin
            left_d = left_q - 6'h1;
            blk_d = blk_q + 3'h1;
            if (left_q == 6'h1) begin
              state_d = S_INIT_END;
              irdy_n_d = 1'b1;
              done_d = 1'b1;
            end else if (init_data_ready || (fast_q && blk_d != 3'h0)) begin
              ad_d = init_data;
              pop_d = 1'b1;
              frame_n_d = (left_q == 6'h2);
            end else begin
              irdy_n_d = 1'b1;
            end
          end else if (irdy_n_q && init_data_ready) begin
            irdy_n_d = 1'b0;
            ad_d = init_data;
            pop_d = 1'b1;
            frame_n_d = (left_q == 6'h1);
          end
          // A target pause with initiator ready low leaves every line standing until it is ready.
        end
        S_INIT_END: begin
          state_d = S_IDLE;
          frame_oe_d = 1'b0;
          ad_oe_d = 1'b0;
        end
        S_TGT_DATA: begin
          if (!irdy_n_s) begin
            tdata_d = ad_s;
            tbe_d = cbe_n_s;
            tvalid_d = 1'b1;
            if (frame_n_s) begin
              state_d = S_TGT_END;
              trdy_n_d = 1'b1;
            end
          end
        end
        S_TGT_END: begin
          state_d = S_IDLE;
        end
        default: begin
          state_d = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      gnt_n_q <= 1'b1;
      st_q <= `ST_RESET;
      fast_q <= 1'b0;
      frame_n_q <= 1'b1;
      frame_oe_q <= 1'b0;
      irdy_n_q <= 1'b1;
      trdy_n_q <= 1'b1;
      ad_q <= '0;
      ad_oe_q <= 1'b0;
      cbe_q <= '0;
      taddr_q <= '0;
      tcmd_q <= '0;
      tdata_q <= '0;
      tbe_q <= '0;
      left_q <= '0;
      blk_q <= '0;
      pop_q <= 1'b0;
      done_q <= 1'b0;
      hit_q <= 1'b0;
      tvalid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      gnt_n_q <= gnt_n_d;
      st_q <= st_d;
      fast_q <= fast_d;
      frame_n_q <= frame_n_d;
      frame_oe_q <= frame_oe_d;
      irdy_n_q <= irdy_n_d;
      trdy_n_q <= trdy_n_d;
      ad_q <= ad_d;
      ad_oe_q <= ad_oe_d;
      cbe_q <= cbe_d;
      taddr_q <= taddr_d;
      tcmd_q <= tcmd_d;
      tdata_q <= tdata_d;
      tbe_q <= tbe_d;
      left_q <= left_d;
      blk_q <= blk_d;
      pop_q <= pop_d;
      done_q <= done_d;
      hit_q <= hit_d;
      tvalid_q <= tvalid_d;
    end
  end

  // --------------------------------------------------------------------------
  // Data strobes
  // --------------------------------------------------------------------------
  // Strobes run only for fast writes, where the device sources the data.
  logic stb_src;
  assign stb_src = (state_q == S_INIT_DATA) && fast_q;

  gport_strobe_pair u_stb0 (
    .core_clk(core_clk),
    .resetn(resetn),
    .send(pop_q && stb_src),
    .source(stb_src),
    .stb(ad_stb0),
    .stb_n(ad_stb0_n),
    .stb_oe(ad_stb0_oe)
  );

  gport_strobe_pair u_stb1 (
    .core_clk(core_clk),
    .resetn(resetn),
    .send(pop_q && stb_src),
    .source(stb_src),
    .stb(ad_stb1),
    .stb_n(ad_stb1_n),
    .stb_oe(ad_stb1_oe)
  );

  assign grant_n = gnt_n_q;
  assign st = st_q;
  assign frame_n_out = frame_n_q;
  assign frame_oe = frame_oe_q;
  assign port_initiator_ready_n_out = irdy_n_q;
  assign port_initiator_ready_n_oe = is_init(state_q);
  assign port_target_ready_n_out = trdy_n_q;
  assign port_target_ready_n_oe = is_tgt(state_q);
  assign ad_out = ad_q;
  assign ad_oe = ad_oe_q;
  assign cbe_n_out = cbe_q;
  assign cbe_oe = ad_oe_q;
  assign init_pop = pop_q;
  assign init_busy = (state_q != S_IDLE);
  assign init_done = done_q;
  assign tgt_hit = hit_q;
  assign tgt_cmd = tcmd_q;
  assign tgt_addr = taddr_q;
  assign tgt_valid = tvalid_q;
  assign tgt_data = tdata_q;
  assign tgt_be_n = tbe_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_last_phase;
    (state_q == S_INIT_DATA) && frame_n_q && phase_done;
  endsequence

  AST_GRANT_WITH_STATUS: assert property (edge_s |=> (grant_n == !$past(grant_req)) && (st == $past(grant_code)))
    else $error("Grant and status not updated together.");
  AST_FRAME_DRIVEN: assert property (is_init(state_q) && state_q != S_INIT_END |-> frame_oe)
    else $error("Frame not driven during own access.");
  // The end state lasts until the next port edge, which is eight core cycles away.
  AST_FRAME_ENDS: assert property (s_last_phase |=> state_q == S_INIT_END ##[1:9] !frame_oe)
    else $error("Frame not released after last phase.");
  AST_FRAME_RELEASE: assert property ((state_q == S_INIT_END) && edge_s |=> !frame_oe && !ad_oe)
    else $error("Frame or lanes still driven after the access ended.");
  AST_TGT_CAPTURE: assert property (hit_q |-> tgt_addr == $past(ad_s) && tgt_cmd == $past(cbe_n_s))
    else $error("Target capture does not match first frame edge.");
  AST_QUEUE_IGNORE: assert property (hit_q |-> !$past(queue_mode))
    else $error("Frame taken while queued mode selected.");
  AST_IRDY_ROLE: assert property (port_initiator_ready_n_oe |-> !is_tgt(state_q))
    else $error("Initiator ready driven as target.");
  AST_TRDY_ROLE: assert property (port_target_ready_n_oe |-> !is_init(state_q))
    else $error("Target ready driven as initiator.");
  AST_IRDY_WITH_DATA: assert property ($fell(irdy_n_q) |-> $past(init_data_ready))
    else $error("Initiator ready asserted without data.");
  AST_FW_NO_MIDBLOCK_WAIT: assert property ((state_q == S_INIT_DATA) && fast_q && $rose(irdy_n_q) |-> blk_q == 3'h0)
    else $error("Fast write paused inside a block.");
  AST_STROBE_SOURCE: assert property (ad_stb0_oe || ad_stb1_oe |-> $past(stb_src))
    else $error("Strobes driven while not sourcing data.");

endmodule // gport_ctrl

// ===== gport_partner.sv
// ----------------------------------------------------------------------------
// Graphics controller model, acting as framed master or as target
// ----------------------------------------------------------------------------
module gport_partner (
  // Port clock and status
  input wire logic port_clk,
  input wire logic grant_n,
  input wire logic [2:0] st,
  // Resolved bus lines
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  // Model drive
  output logic m_oe,
  output logic m_frame_n,
  output logic m_irdy_n,
  output logic [31:0] m_ad,
  output logic [3:0] m_cbe_n,
  output logic s_oe,
  output logic m_trdy_n
);
  timeunit 1ns;
  timeprecision 1ns;

  logic tgt_q = 1'b0;
  logic stall_blk = 1'b0;
  logic [2:0] st_q = 3'h0;
  logic [31:0] addr_q;
  logic [3:0] cmd_q;
  logic [3:0] be_q;
  logic [31:0] rx [0:15];
  int rx_cnt = 0;
  int stalls = 0;
  int hold = 0;

  // Framed transfers only: no 2x/4x sideband mode is configured, so the sideband pair stays released.
  logic sb_mode = 1'b0;
  logic sb_stb, sb_stb_n, sb_oe;
  assign sb_oe = sb_mode;
  assign sb_stb = sb_mode & port_clk;
  assign sb_stb_n = ~sb_stb;

  initial begin
    m_oe = 1'b0;
    m_frame_n = 1'b1;
    m_irdy_n = 1'b1;
    m_ad = 32'h0;
    m_cbe_n = 4'h0;
    s_oe = 1'b0;
    m_trdy_n = 1'b1;
  end

  // Lines are sampled on the rising port edge and changed on the falling one, so the
  // core's synchroniser never catches a line in motion.
  always @(posedge port_clk) begin
    if (grant_n == 1'b0) st_q = st;
    if (!m_oe && !tgt_q && frame_n == 1'b0) begin
      tgt_q = 1'b1;
      addr_q = ad;
      cmd_q = cbe_n;
    end else if (tgt_q && !irdy_n && !trdy_n) begin
      rx[rx_cnt] = ad;
      be_q = cbe_n;
      rx_cnt++;
      if (stall_blk && rx_cnt % 8 == 0) hold = 2;
    end else if (tgt_q && !frame_n && rx_cnt % 8 != 0) begin
      stalls++;
    end
    if (tgt_q && frame_n && irdy_n) tgt_q = 1'b0;
  end

  always @(negedge port_clk) begin
    s_oe = tgt_q;
    m_trdy_n = !(tgt_q && hold == 0);
    if (hold > 0) hold--;
  end

  task automatic master_write(input logic [31:0] a, input logic [3:0] c, input int n, output int acks);
    int w;
    acks = 0;
    @(negedge port_clk);
    m_oe = 1'b1;
    m_frame_n = 1'b0;
    m_ad = a;
    m_cbe_n = c;
    for (int i = 0; i < n; i++) begin
      @(negedge port_clk);
      m_irdy_n = 1'b0;
      m_frame_n = (i == n - 1);
      m_ad = 32'hBEEF_0000 + 32'(i);
      m_cbe_n = 4'(i);
      w = 0;
      do begin
        @(posedge port_clk);
        w++;
      end while (trdy_n !== 1'b0 && w < 4);
      if (trdy_n === 1'b0) acks++;
    end
    @(negedge port_clk);
    m_irdy_n = 1'b1;
    @(negedge port_clk);
    m_oe = 1'b0;
  endtask
endmodule // gport_partner

// ===== gport_pkg.sv
package gport_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_INIT_ADDR,
    S_INIT_DATA,
    S_INIT_END,
    S_TGT_DATA,
    S_TGT_END
  } port_state_type;

endpackage

// ===== gport_regs.svh
`ifndef GPORT_REGS_SVH
`define GPORT_REGS_SVH

// ----------------------------------------------------------------------------
// Status codes sent with the grant
// ----------------------------------------------------------------------------
`define ST_READ_LO 3'h0
`define ST_READ_HI 3'h1
`define ST_WRITE_LO 3'h2
`define ST_WRITE_HI 3'h3
`define ST_FRAME_GO 3'h7

// ----------------------------------------------------------------------------
// Widths, reset values and block sizing
// ----------------------------------------------------------------------------
`define AD_WIDTH 32
`define CBE_WIDTH 4
`define ST_WIDTH 3
`define WORDS_WIDTH 6
`define BLK_WIDTH 3
`define FW_BLOCK_BYTES 32
`define BYTES_PER_WORD 4
`define FW_BLOCK_WORDS (`FW_BLOCK_BYTES / `BYTES_PER_WORD)
`define SYNC_WIDTH 40
`define CBE_ALL_BYTES 4'h0
`define ST_RESET 3'h0

`endif

// ===== gport_strobe_pair.sv
module gport_strobe_pair (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Control
  input wire logic send,
  input wire logic source,
  // Strobe pins
  output logic stb,
  output logic stb_n,
  output logic stb_oe
);

  logic stb_q, stb_d;
  logic stb_n_q, stb_n_d;
  logic oe_q, oe_d;

  always_comb begin
    stb_d = stb_q;
    stb_n_d = stb_n_q;
    oe_d = source;
    if (send) begin
      stb_d = ~stb_q;
      stb_n_d = stb_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stb_q <= 1'b0;
      stb_n_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      stb_q <= stb_d;
      stb_n_q <= stb_n_d;
      oe_q <= oe_d;
    end
  end

  assign stb = stb_q;
  assign stb_n = stb_n_q;
  assign stb_oe = oe_q;

  AST_STB_DIFF: assert property (@(posedge core_clk) disable iff (!resetn) stb_n == ~stb)
    else $error("Strobe pair lost its complement.");
  AST_STB_TOGGLE: assert property (@(posedge core_clk) disable iff (!resetn)
    send |=> stb != $past(stb))
    else $error("Strobe did not toggle for a launched word.");

endmodule // gport_strobe_pair

// ===== tb_gport_ctrl.sv
`include "gport_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

// ----------------------------------------------------------------------------
// Port controller bench
// ----------------------------------------------------------------------------
module tb_gport_ctrl;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk, port_clk, resetn;
  logic grant_req, queue_mode, init_start, init_fast, init_data_ready;
  logic [2:0] grant_code, st;
  logic [3:0] init_cmd, tgt_cmd, tgt_be_n, cbe_n_out, m_cbe_n;
  logic [31:0] init_addr, init_data, tgt_addr, tgt_data, ad_out, m_ad;
  logic [5:0] init_words;
  logic init_pop, init_busy, init_done, tgt_hit, tgt_valid, grant_n;
  logic frame_n_out, frame_oe, ir_out, ir_oe, tr_out, tr_oe, ad_oe, cbe_oe;
  logic ad_stb0, ad_stb0_n, ad_stb0_oe, ad_stb1, ad_stb1_n, ad_stb1_oe;
  logic m_oe, m_frame_n, m_irdy_n, s_oe, m_trdy_n, s0_q, s1_q;
  int error_cnt = 0;
  int samples_checked = 0;
  int tog0, tog1, stb_on, pair_bad, tgt_hits, tv_cnt;

  // Released control lines rise through pull-ups; released data lanes show a moving pattern.
  wire logic frame_n_in = frame_oe ? frame_n_out : (m_oe ? m_frame_n : 1'b1);
  wire logic ir_in = ir_oe ? ir_out : (m_oe ? m_irdy_n : 1'b1);
  wire logic tr_in = tr_oe ? tr_out : (s_oe ? m_trdy_n : 1'b1);
  wire logic [31:0] ad_in = ad_oe ? ad_out : (m_oe ? m_ad : {32{port_clk}});
  wire logic [3:0] cbe_n_in = cbe_oe ? cbe_n_out : (m_oe ? m_cbe_n : {4{port_clk}});

  gport_ctrl dut (
    .core_clk, .resetn, .port_clk, .grant_req, .grant_code, .queue_mode,
    .init_start, .init_fast, .init_cmd, .init_addr, .init_words, .init_data_ready, .init_data,
    .init_pop, .init_busy, .init_done, .tgt_hit, .tgt_cmd, .tgt_addr, .tgt_valid, .tgt_data,
    .tgt_be_n, .grant_n, .st, .frame_n_in, .frame_n_out, .frame_oe,
    .port_initiator_ready_n_in(ir_in), .port_initiator_ready_n_out(ir_out), .port_initiator_ready_n_oe(ir_oe),
    .port_target_ready_n_in(tr_in), .port_target_ready_n_out(tr_out), .port_target_ready_n_oe(tr_oe),
    .ad_in, .ad_out, .ad_oe, .cbe_n_in, .cbe_n_out, .cbe_oe,
    .ad_stb0, .ad_stb0_n, .ad_stb0_oe, .ad_stb1, .ad_stb1_n, .ad_stb1_oe
  );

  gport_partner part (
    .port_clk, .grant_n, .st, .frame_n(frame_n_in), .irdy_n(ir_in), .trdy_n(tr_in), .ad(ad_in),
    .cbe_n(cbe_n_in), .m_oe, .m_frame_n, .m_irdy_n, .m_ad, .m_cbe_n, .s_oe, .m_trdy_n
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    port_clk = 1'b0;
    #7;
    forever #160 port_clk = ~port_clk;
  end

  always @(posedge core_clk) begin
    s0_q <= ad_stb0;
    s1_q <= ad_stb1;
    if (ad_stb0_oe === 1'b1 && ad_stb0 !== s0_q) tog0++;
    if (ad_stb1_oe === 1'b1 && ad_stb1 !== s1_q) tog1++;
    if (ad_stb0_oe === 1'b1 || ad_stb1_oe === 1'b1) stb_on++;
    if ((ad_stb0_oe && ad_stb0_n !== ~ad_stb0) || (ad_stb1_oe && ad_stb1_n !== ~ad_stb1)) pair_bad++;
    if (tgt_hit === 1'b1) begin
      tgt_hits++;
      `CHK("tgt_addr", 32'h00AB_C000, tgt_addr)
      `CHK("tgt_cmd", 4'h6, tgt_cmd)
    end
    if (tgt_valid === 1'b1) begin
      `CHK("tgt_data", 32'hBEEF_0000 + 32'(tv_cnt), tgt_data)
      `CHK("tgt_be_n", 4'(tv_cnt), tgt_be_n)
      tv_cnt++;
    end
  end

  always @(posedge core_clk) if (init_pop === 1'b1) init_data <= init_data + 32'h1;

  // Data runs dry while the target pauses after the first block, so a fast write must wait there.
  always @(posedge core_clk) init_data_ready <= !(part.rx_cnt == 8 && part.hold > 0);

  task automatic wait_port(input int n);
    repeat (n) @(posedge port_clk);
    repeat (5) @(negedge core_clk);
  endtask

  task automatic t_grant();
    logic [2:0] codes [5] = '{`ST_READ_LO, `ST_READ_HI, `ST_WRITE_LO, `ST_WRITE_HI, `ST_FRAME_GO};
    foreach (codes[i]) begin
      @(posedge core_clk);
      grant_req <= 1'b1;
      grant_code <= codes[i];
      wait_port(2);
      `CHK("grant_n", 1'b0, grant_n)
      `CHK("st", codes[i], st)
      `CHK("model st", codes[i], part.st_q)
    end
    @(posedge core_clk);
    grant_req <= 1'b0;
    grant_code <= `ST_WRITE_LO;
    wait_port(2);
    `CHK("grant_n", 1'b1, grant_n)
    `CHK("st", `ST_WRITE_LO, st)
    `CHK("model st", `ST_FRAME_GO, part.st_q)
  endtask

  task automatic t_init(input logic fast, input logic [5:0] n, input logic stall);
    int t;
    part.rx_cnt = 0;
    part.stalls = 0;
    part.stall_blk = stall;
    tog0 = 0;
    tog1 = 0;
    stb_on = 0;
    pair_bad = 0;
    @(posedge core_clk);
    init_fast <= fast;
    init_words <= n;
    init_addr <= 32'h0001_2340 + 32'(n);
    init_data <= 32'hC0DE_0000;
    init_start <= 1'b1;
    t = 0;
    while (init_busy !== 1'b1 && t < 40) begin
      @(negedge core_clk);
      t++;
    end
    @(posedge core_clk);
    init_start <= 1'b0;
    t = 0;
    while (init_done !== 1'b1 && t < 2000) begin
      @(negedge core_clk);
      t++;
    end
    `CHK("init_done", 1'b1, init_done)
    wait_port(2);
    `CHK("init_busy", 1'b0, init_busy)
    `CHK("frame_oe", 1'b0, frame_oe)
    `CHK("addr", 32'h0001_2340 + 32'(n), part.addr_q)
    `CHK("cmd", 4'h7, part.cmd_q)
    `CHK("words", 32'(n), part.rx_cnt)
    for (int i = 0; i < n; i++) `CHK("word", 32'hC0DE_0000 + 32'(i), part.rx[i])
    `CHK("be", `CBE_ALL_BYTES, part.be_q)
    if (fast) begin
      `CHK("stalls", 0, part.stalls)
      `CHK("stb0 edges", 32'(n), tog0)
      `CHK("stb1 edges", 32'(n), tog1)
      `CHK("stb pair", 0, pair_bad)
    end else begin
      `CHK("stb_on", 0, stb_on)
    end
  endtask

  task automatic t_tgt(input logic qm, input int n);
    int acks;
    @(posedge core_clk);
    queue_mode <= qm;
    tv_cnt = 0;
    tgt_hits = 0;
    stb_on = 0;
    part.master_write(32'h00AB_C000, 4'h6, n, acks);
    wait_port(2);
    `CHK("hits", qm ? 0 : 1, tgt_hits)
    `CHK("valids", qm ? 0 : n, tv_cnt)
    `CHK("acks", qm ? 0 : n, acks)
    `CHK("stb_on", 0, stb_on)
    `CHK("sb_oe", 1'b0, part.sb_oe)
    `CHK("sb pair", ~part.sb_stb, part.sb_stb_n)
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    grant_req = 1'b0;
    grant_code = 3'h0;
    queue_mode = 1'b0;
    init_start = 1'b0;
    init_fast = 1'b0;
    init_cmd = 4'h7;
    init_addr = 32'h0;
    init_words = 6'h1;
    init_data_ready = 1'b1;
    init_data = 32'h0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_grant();
    t_init(1'b0, 6'h1, 1'b0);
    t_init(1'b0, 6'h3, 1'b0);
    t_init(1'b1, 6'hA, 1'b1);
    t_tgt(1'b1, 1);
    t_tgt(1'b0, 3);
    results();
  end

  // The whole sequence needs well under 100 us; four times that means a hang.
  initial begin
    #400000;
    error_cnt++;
    results();
  end
endmodule // tb_gport_ctrl
